// file: pkg/hmb_pkg.sv
// package: constants and carrier types of the host mailbox and doorbell
package hmb_pkg;

  // interrupt source bit positions (status and enable share them)
  localparam int SRC_BRIDGE   = 0;
  localparam int SRC_DOORBELL = 1;
  localparam int SRC_MESSAGE  = 2;
  localparam int SRC_W        = 3;

  // reset values
  localparam logic [31:0]      RST_WORD   = 32'h0000_0000;
  localparam logic [SRC_W-1:0] RST_ENABLE = 3'h0;

  // bridge options bit that routes to the embedded controller
  localparam int BRIDGE_OPT_IRQ_BIT = 13;

  // boot redirection
  localparam int BOOT_WORDS = 8;
  localparam int BOOT_IDX_W = 3;

  // boot fetch state
  typedef enum logic [1:0] {
    HMB_BOOT_IDLE = 2'b00,
    HMB_BOOT_SERVE = 2'b01,
    HMB_BOOT_DONE = 2'b10
  } hmb_boot_t;

  // one register's write and read strobes with data
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] data;
  } hmb_acc_t;

  // whole state of the block except the boot words
  typedef struct packed {
    logic [31:0]      resource;
    logic             buf_valid;
    logic [31:0]      out_ptr;
    logic             out_pending;
    logic [31:0]      in_ptr;
    logic             in_irq;
    logic             in_busy;
    logic [31:0]      doorbell;
    logic [SRC_W-1:0] enable;
    logic [31:0]      rdata;
    hmb_boot_t        boot;
    logic [BOOT_IDX_W-1:0] boot_idx;
    logic [31:0]      boot_instr;
  } hmb_state_t;

endpackage : hmb_pkg

// file: src/hmb_mailbox.sv
// design: host/processor mailbox, doorbell and host interrupt logic
//
// How it works
// - host write to resource register stores address, sets buffer valid
// - resource register read returns address and clears buffer valid
// - any write of outbound pointer sets outbound message pending
// - host read of outbound pointer clears outbound message pending
// - host irq asserted when any status bit has its enable set
// - host irq is a level held while enabled condition persists
// - bridge interrupt to host recorded as its own status bit
// - bridge options bit 13 interrupt routed to embedded controller
// - host pointer write stores address, raises inbound irq, sets busy
// - primary-address read of inbound pointer returns it, drops irq
// - alternate-address read of inbound pointer clears busy flag
// - processor doorbell write sets bits whose data bit is one
// - host doorbell write clears bits whose data bit is one
// - doorbell status bit set while any doorbell bit is one
// - fixed processor address window mapped onto memory controller
// - first eight fetches served from eight loaded boot instruction registers
// - status bits follow their sources; status is read only
// - one enable bit per source, all zero after reset
// - doorbell holds 32 independent bits readable by the host
`timescale 1ns/1ps
`default_nettype none

module hmb_mailbox #(
  parameter int          WIN_AW   = 24,
  parameter logic [31:0] WIN_BASE = 32'h0000_0000,
  parameter logic [31:0] MEM_BASE = 32'h0000_0000
) (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // host side accesses
  input  wire hmb_pkg::hmb_acc_t       host_resource,
  input  wire logic                    host_out_ptr_rd,
  input  wire logic                    host_in_ptr_wr,
  input  wire logic [31:0]             host_in_ptr_wdata,
  input  wire hmb_pkg::hmb_acc_t       host_doorbell,
  input  wire logic                    host_status_rd,
  input  wire hmb_pkg::hmb_acc_t       host_enable,
  // processor side accesses
  input  wire logic                    cpu_resource_rd,
  input  wire logic                    cpu_out_ptr_wr,
  input  wire logic [31:0]             cpu_out_ptr_wdata,
  input  wire logic                    cpu_in_ptr_rd,
  input  wire logic                    cpu_in_ptr_alt_rd,
  input  wire hmb_pkg::hmb_acc_t       cpu_doorbell,
  // bridge interrupts
  input  wire logic                    bridge_host_irq,
  input  wire logic [31:0]             bridge_options,
  // boot redirection
  input  wire logic                    embedded_core_reset,
  input  wire logic                    boot_ld,
  input  wire logic [2:0]              boot_ld_idx,
  input  wire logic [31:0]             boot_ld_data,
  input  wire logic                    fetch_req,
  // memory window
  input  wire logic [31:0]             bus_addr,
  // outputs
  output logic [31:0]                  rd_data,
  output logic                         outbound_buffer_valid,
  output logic                         inbound_message_busy,
  output logic                         inbound_message_irq,
  output logic                         bridge_cpu_irq,
  output logic [hmb_pkg::SRC_W-1:0]    host_irq_status,
  output logic                         inta_n,
  output logic                         mem_hit,
  output logic [31:0]                  mem_addr,
  output logic                         boot_hit,
  output logic [31:0]                  boot_instr
);

  initial begin
    if (WIN_AW < 1 || WIN_AW > 32) begin
      $error("WIN_AW out of range");
    end
  end

  hmb_pkg::hmb_state_t s_r;
  hmb_pkg::hmb_state_t s_nxt;
  logic [31:0] boot_mem [hmb_pkg::BOOT_WORDS];
  logic [hmb_pkg::SRC_W-1:0] status;

  always_comb begin
    status = '0;
    status[hmb_pkg::SRC_BRIDGE]   = bridge_host_irq;
    status[hmb_pkg::SRC_DOORBELL] = |s_r.doorbell;
    status[hmb_pkg::SRC_MESSAGE]  = s_r.out_pending;
  end

  function automatic logic win_match(input logic [31:0] a);
    logic [31:0] msk;
    msk = ~((32'hFFFF_FFFF >> (32 - WIN_AW)));
    win_match = (a & msk) == (WIN_BASE & msk);
  endfunction : win_match

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = s_r.rdata;
    if (host_resource.wr) begin
      s_nxt.resource  = host_resource.data;
      s_nxt.buf_valid = 1'b1;
    end else if (cpu_resource_rd || host_resource.rd) begin
      s_nxt.buf_valid = 1'b0;
    end
    if (cpu_out_ptr_wr) begin
      s_nxt.out_ptr     = cpu_out_ptr_wdata;
      s_nxt.out_pending = 1'b1;
    end else if (host_out_ptr_rd) begin
      s_nxt.out_pending = 1'b0;
    end
    if (host_in_ptr_wr) begin
      s_nxt.in_ptr  = host_in_ptr_wdata;
      s_nxt.in_irq  = 1'b1;
      s_nxt.in_busy = 1'b1;
    end else begin
      if (cpu_in_ptr_rd) begin
        s_nxt.in_irq = 1'b0;
      end
      if (cpu_in_ptr_alt_rd) begin
        s_nxt.in_busy = 1'b0;
      end
    end
    // set under mask, reset under mask; set wins
    s_nxt.doorbell = s_r.doorbell;
    if (host_doorbell.wr) begin
      s_nxt.doorbell = s_nxt.doorbell & ~host_doorbell.data;
    end
    if (cpu_doorbell.wr) begin
      s_nxt.doorbell = s_nxt.doorbell | cpu_doorbell.data;
    end
    if (host_enable.wr) begin
      s_nxt.enable = host_enable.data[hmb_pkg::SRC_W-1:0];
    end
    // read data mux
    if (host_resource.rd || cpu_resource_rd) begin
      s_nxt.rdata = s_r.resource;
    end else if (host_out_ptr_rd) begin
      s_nxt.rdata = s_r.out_ptr;
    end else if (cpu_in_ptr_rd || cpu_in_ptr_alt_rd) begin
      s_nxt.rdata = s_r.in_ptr;
    end else if (host_doorbell.rd || cpu_doorbell.rd) begin
      s_nxt.rdata = s_r.doorbell;
    end else if (host_status_rd) begin
      s_nxt.rdata = {29'h0, status};
    end else if (host_enable.rd) begin
      s_nxt.rdata = {29'h0, s_r.enable};
    end
    // first eight fetches after core reset served from boot registers
    case (s_r.boot)
      hmb_pkg::HMB_BOOT_IDLE: begin
        if (!embedded_core_reset && fetch_req) begin
          s_nxt.boot       = hmb_pkg::HMB_BOOT_SERVE;
          s_nxt.boot_instr = boot_mem[0];
          s_nxt.boot_idx   = 3'h1;
        end
      end
      hmb_pkg::HMB_BOOT_SERVE: begin
        // index wraps to zero once word 7 has been shown
        if (fetch_req && s_r.boot_idx == 3'h0) begin
          s_nxt.boot = hmb_pkg::HMB_BOOT_DONE;
        end else if (fetch_req) begin
          s_nxt.boot_instr = boot_mem[s_r.boot_idx];
          s_nxt.boot_idx   = s_r.boot_idx + 3'h1;
        end
      end
      hmb_pkg::HMB_BOOT_DONE: begin
        s_nxt.boot = hmb_pkg::HMB_BOOT_DONE;
      end
      default: begin
        s_nxt.boot = hmb_pkg::HMB_BOOT_IDLE;
      end
    endcase
    if (embedded_core_reset) begin
      s_nxt.boot     = hmb_pkg::HMB_BOOT_IDLE;
      s_nxt.boot_idx = 3'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{resource: hmb_pkg::RST_WORD, buf_valid: 1'b0,
               out_ptr: hmb_pkg::RST_WORD, out_pending: 1'b0,
               in_ptr: hmb_pkg::RST_WORD, in_irq: 1'b0, in_busy: 1'b0,
               doorbell: hmb_pkg::RST_WORD, enable: hmb_pkg::RST_ENABLE,
               rdata: hmb_pkg::RST_WORD, boot: hmb_pkg::HMB_BOOT_IDLE,
               boot_idx: 3'h0, boot_instr: hmb_pkg::RST_WORD};
    end else begin
      s_r <= s_nxt;
    end
  end

  // boot words loaded by software before core reset release
  always_ff @(posedge mclk) begin
    if (boot_ld) begin
      boot_mem[boot_ld_idx] <= boot_ld_data;
    end
  end

  assign rd_data               = s_r.rdata;
  assign outbound_buffer_valid = s_r.buf_valid;
  assign inbound_message_busy  = s_r.in_busy;
  assign inbound_message_irq   = s_r.in_irq;
  assign host_irq_status       = status;
  assign inta_n = ~|(status & s_r.enable);
  assign bridge_cpu_irq = bridge_options[hmb_pkg::BRIDGE_OPT_IRQ_BIT];
  assign mem_hit  = win_match(bus_addr);
  assign mem_addr = MEM_BASE + (bus_addr & (32'hFFFF_FFFF >> (32 - WIN_AW)));
  assign boot_hit   = s_r.boot == hmb_pkg::HMB_BOOT_SERVE;
  assign boot_instr = s_r.boot_instr;

  // assertions
  property p_res_set;
    @(posedge mclk) disable iff (!rst_n)
      host_resource.wr |=> outbound_buffer_valid
        && s_r.resource == $past(host_resource.data);
  endproperty
  a_res_set: assert property (p_res_set) else $error("valid not set");

  property p_res_clr;
    @(posedge mclk) disable iff (!rst_n)
      (cpu_resource_rd && !host_resource.wr) |=> !outbound_buffer_valid;
  endproperty
  a_res_clr: assert property (p_res_clr) else $error("valid not cleared");

  property p_pend_set;
    @(posedge mclk) disable iff (!rst_n)
      cpu_out_ptr_wr |=> host_irq_status[hmb_pkg::SRC_MESSAGE];
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending not set");

  property p_pend_clr;
    @(posedge mclk) disable iff (!rst_n)
      (host_out_ptr_rd && !cpu_out_ptr_wr)
        |=> !host_irq_status[hmb_pkg::SRC_MESSAGE];
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending stuck");

  property p_inta;
    @(posedge mclk) disable iff (!rst_n)
      inta_n == !(|(host_irq_status & s_r.enable));
  endproperty
  a_inta: assert property (p_inta) else $error("irq level wrong");

  property p_in_wr;
    @(posedge mclk) disable iff (!rst_n)
      host_in_ptr_wr |=> inbound_message_irq && inbound_message_busy;
  endproperty
  a_in_wr: assert property (p_in_wr) else $error("inbound not raised");

  property p_in_rd;
    @(posedge mclk) disable iff (!rst_n)
      (cpu_in_ptr_rd && !host_in_ptr_wr) |=> !inbound_message_irq
        && rd_data == $past(s_r.in_ptr);
  endproperty
  a_in_rd: assert property (p_in_rd) else $error("inbound irq stuck");

  property p_db_set;
    @(posedge mclk) disable iff (!rst_n)
      cpu_doorbell.wr |=> (s_r.doorbell & $past(cpu_doorbell.data))
        == $past(cpu_doorbell.data);
  endproperty
  a_db_set: assert property (p_db_set) else $error("doorbell not set");

  property p_db_src;
    @(posedge mclk) disable iff (!rst_n)
      host_irq_status[hmb_pkg::SRC_DOORBELL] == (|s_r.doorbell);
  endproperty
  a_db_src: assert property (p_db_src) else $error("doorbell src");

  property p_db_clr;
    @(posedge mclk) disable iff (!rst_n)
      (host_doorbell.wr && !cpu_doorbell.wr)
        |=> (s_r.doorbell & $past(host_doorbell.data)) == 32'h0;
  endproperty
  a_db_clr: assert property (p_db_clr) else $error("doorbell stuck");

  property p_busy_clr;
    @(posedge mclk) disable iff (!rst_n)
      (cpu_in_ptr_alt_rd && !host_in_ptr_wr) |=> !inbound_message_busy;
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy stuck");

  property p_res_hold;
    @(posedge mclk) disable iff (!rst_n)
      (!host_resource.wr && !host_resource.rd && !cpu_resource_rd)
        |=> $stable(outbound_buffer_valid);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("valid moved");

  property p_bridge_src;
    @(posedge mclk) disable iff (!rst_n)
      host_irq_status[hmb_pkg::SRC_BRIDGE] == bridge_host_irq;
  endproperty
  a_bridge_src: assert property (p_bridge_src) else $error("bridge src");

  // boot fetch steps
  sequence s_boot_go;
    s_r.boot == hmb_pkg::HMB_BOOT_IDLE && !embedded_core_reset && fetch_req;
  endsequence
  sequence s_boot_last;
    boot_hit && fetch_req && s_r.boot_idx == 3'h0 && !embedded_core_reset;
  endsequence

  property p_boot_go;
    @(posedge mclk) disable iff (!rst_n)
      s_boot_go |=> boot_hit && boot_instr == $past(boot_mem[0]);
  endproperty
  a_boot_go: assert property (p_boot_go) else $error("boot start");

  property p_boot_end;
    @(posedge mclk) disable iff (!rst_n)
      s_boot_last |=> !boot_hit;
  endproperty
  a_boot_end: assert property (p_boot_end) else $error("boot end");

endmodule : hmb_mailbox
`default_nettype wire

// file: verif/hmb_cpu_model.sv
// partner: embedded processor side register accesses
`timescale 1ns/1ps
`default_nettype none
module hmb_cpu_model (
  // clock and buffer flag
  input  wire logic             mclk,
  input  wire logic             outbound_buffer_valid,
  // processor strobes
  output logic                  cpu_resource_rd,
  output logic                  cpu_out_ptr_wr,
  output logic [31:0]           cpu_out_ptr_wdata,
  output logic                  cpu_in_ptr_rd,
  output logic                  cpu_in_ptr_alt_rd,
  output var hmb_pkg::hmb_acc_t cpu_doorbell
);
  initial begin
    {cpu_resource_rd, cpu_out_ptr_wr, cpu_in_ptr_rd, cpu_in_ptr_alt_rd} = '0;
    cpu_out_ptr_wdata = 32'h0;
    cpu_doorbell = '0;
  end
  // one access of kind k after gap idle cycles
  task automatic op(input logic [2:0] k, input logic [31:0] d, input int gap);
    repeat (gap) @(negedge mclk);
    @(negedge mclk);
    cpu_resource_rd = (k == 3'h1) && outbound_buffer_valid;
    cpu_out_ptr_wr = (k == 3'h2);
    cpu_out_ptr_wdata = d;
    cpu_in_ptr_rd = (k == 3'h3);
    cpu_in_ptr_alt_rd = (k == 3'h4);
    cpu_doorbell.wr = (k == 3'h5);
    cpu_doorbell.rd = (k == 3'h6);
    cpu_doorbell.data = d;
    @(negedge mclk);
    {cpu_resource_rd, cpu_out_ptr_wr, cpu_in_ptr_rd, cpu_in_ptr_alt_rd} = '0;
    {cpu_doorbell.wr, cpu_doorbell.rd} = 2'h0;
    // released lines show the inverse
    {cpu_out_ptr_wdata, cpu_doorbell.data} = {~d, ~d};
  endtask : op
endmodule : hmb_cpu_model
`default_nettype wire

// file: verif/hmb_mailbox_tb.sv
// bench: mailbox, doorbell and host interrupt checks
`timescale 1ns/1ps
`default_nettype none
module hmb_mailbox_tb;
  logic              mclk, rst_n, host_out_ptr_rd, host_in_ptr_wr;
  logic              host_status_rd, bridge_host_irq, embedded_core_reset;
  logic              boot_ld, fetch_req, cpu_resource_rd, cpu_out_ptr_wr;
  logic              cpu_in_ptr_rd, cpu_in_ptr_alt_rd, outbound_buffer_valid;
  logic              inbound_message_busy, inbound_message_irq;
  logic              bridge_cpu_irq, inta_n, mem_hit, boot_hit;
  logic [2:0]        boot_ld_idx, host_irq_status;
  logic [31:0]       host_in_ptr_wdata, bridge_options, bus_addr, boot_ld_data;
  logic [31:0]       cpu_out_ptr_wdata, rd_data, mem_addr, boot_instr, d, dbx;
  hmb_pkg::hmb_acc_t host_resource, host_doorbell, host_enable, cpu_doorbell;
  int                n_mismatch, comparisons, cyc, seed;
  logic [31:0]       bw [8];

  hmb_mailbox u_dut (
    .mclk, .rst_n, .host_resource, .host_out_ptr_rd, .host_in_ptr_wr,
    .host_in_ptr_wdata, .host_doorbell, .host_status_rd, .host_enable,
    .cpu_resource_rd, .cpu_out_ptr_wr, .cpu_out_ptr_wdata, .cpu_in_ptr_rd,
    .cpu_in_ptr_alt_rd, .cpu_doorbell, .bridge_host_irq, .bridge_options,
    .embedded_core_reset, .boot_ld, .boot_ld_idx, .boot_ld_data, .fetch_req,
    .bus_addr, .rd_data, .outbound_buffer_valid, .inbound_message_busy,
    .inbound_message_irq, .bridge_cpu_irq, .host_irq_status, .inta_n,
    .mem_hit, .mem_addr, .boot_hit, .boot_instr
  );
  hmb_cpu_model u_cpu (
    .mclk, .outbound_buffer_valid, .cpu_resource_rd, .cpu_out_ptr_wr,
    .cpu_out_ptr_wdata, .cpu_in_ptr_rd, .cpu_in_ptr_alt_rd, .cpu_doorbell
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  function automatic logic [31:0] db_nxt(logic [31:0] c, m, logic set);
    return set ? (c | m) : (c & ~m);
  endfunction : db_nxt

  // one host access of kind k
  task automatic host(input logic [2:0] k, input logic [31:0] v);
    @(negedge mclk);
    bus_addr = $random(seed);
    host_resource.wr = (k == 3'h1);
    host_out_ptr_rd = (k == 3'h2);
    host_in_ptr_wr = (k == 3'h3);
    host_doorbell.wr = (k == 3'h4);
    host_doorbell.rd = (k == 3'h5);
    host_enable.wr = (k == 3'h6);
    host_status_rd = (k == 3'h7);
    {host_resource.data, host_in_ptr_wdata} = {v, v};
    {host_doorbell.data, host_enable.data} = {v, v};
    @(negedge mclk);
    {host_resource.wr, host_out_ptr_rd, host_in_ptr_wr, host_doorbell.wr,
     host_doorbell.rd, host_enable.wr, host_status_rd} = '0;
    {host_resource.data, host_in_ptr_wdata} = {~v, ~v};
    {host_doorbell.data, host_enable.data} = {~v, ~v};
  endtask : host

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    seed = 37;
    {rst_n, host_out_ptr_rd, host_in_ptr_wr, host_status_rd} = '0;
    {bridge_host_irq, boot_ld, fetch_req, boot_ld_idx} = '0;
    embedded_core_reset = 1'h1;
    {host_in_ptr_wdata, bridge_options, bus_addr, boot_ld_data} = '0;
    {host_resource, host_doorbell, host_enable} = '0;
    repeat (10) @(negedge mclk);
    rst_n = 1'h1;
    chk("valid", outbound_buffer_valid, 32'h0);
    chk("busy", inbound_message_busy, 32'h0);
    chk("in_irq", inbound_message_irq, 32'h0);
    bridge_host_irq = 1'h1;
    host(3'h7, 32'h0);
    chk("status", host_irq_status, 32'h1);
    chk("status_rd", rd_data, 32'h1);
    chk("inta_n", inta_n, 32'h1);
    host(3'h6, 32'h1);
    chk("inta_n", inta_n, 32'h0);
    bridge_host_irq = 1'h0;
    #1 chk("inta_n", inta_n, 32'h1);
    repeat (4) begin
      bridge_options = $random(seed);
      #1 chk("cpu_irq", bridge_cpu_irq, bridge_options[13]);
    end
    d = $random(seed);
    host(3'h1, d);
    chk("valid", outbound_buffer_valid, 32'h1);
    u_cpu.op(3'h1, 32'h0, 0);
    chk("resource", rd_data, d);
    chk("valid", outbound_buffer_valid, 32'h0);
    host(3'h6, 32'h4);
    d = $random(seed);
    u_cpu.op(3'h2, 32'h0, 2);
    u_cpu.op(3'h2, d, 0);
    chk("status", host_irq_status, 32'h4);
    chk("inta_n", inta_n, 32'h0);
    host(3'h6, 32'h3);
    chk("inta_n", inta_n, 32'h1);
    host(3'h6, 32'h4);
    chk("inta_n", inta_n, 32'h0);
    host(3'h2, 32'h0);
    chk("out_ptr", rd_data, d);
    chk("status", host_irq_status, 32'h0);
    d = $random(seed);
    host(3'h3, d);
    chk("in_irq", inbound_message_irq, 32'h1);
    chk("busy", inbound_message_busy, 32'h1);
    u_cpu.op(3'h3, 32'h0, 1);
    chk("in_ptr", rd_data, d);
    chk("in_irq", inbound_message_irq, 32'h0);
    u_cpu.op(3'h4, 32'h0, 0);
    chk("busy", inbound_message_busy, 32'h0);
    dbx = 32'h0;
    host(3'h6, 32'h2);
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      if (i == 23 || d[31]) begin
        host(3'h4, (i == 23) ? 32'hFFFF_FFFF : d);
        dbx = db_nxt(dbx, (i == 23) ? 32'hFFFF_FFFF : d, 1'h0);
      end else begin
        u_cpu.op(3'h5, d, i % 3);
        dbx = db_nxt(dbx, d, 1'h1);
      end
      host(3'h5, 32'h0);
      chk("doorbell", rd_data, dbx);
      chk("db_status", host_irq_status[1], |dbx);
      chk("inta_n", inta_n, ~|dbx);
      chk("mem_hit", mem_hit, bus_addr[31:24] == 8'h0);
      chk("mem_addr", mem_addr, {8'h0, bus_addr[23:0]});
    end
    bus_addr = 32'h00AB_CDEF;
    #1 chk("mem_hit", mem_hit, 32'h1);
    chk("mem_addr", mem_addr, 32'h00AB_CDEF);
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk);
      bw[i] = $random(seed);
      {boot_ld, boot_ld_idx, boot_ld_data} = {1'b1, i[2:0], bw[i]};
    end
    @(negedge mclk);
    boot_ld = 1'b0;
    embedded_core_reset = 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(negedge mclk);
      fetch_req = 1'b1;
      @(negedge mclk);
      fetch_req = 1'b0;
      chk("boot_hit", boot_hit, (i < 8) ? 32'h1 : 32'h0);
      if (i < 8) chk("boot_instr", boot_instr, bw[i]);
    end
    host(3'h1, 32'h1234_5678);
    u_cpu.op(3'h5, 32'hFFFF_FFFF, 0);
    @(negedge mclk);
    rst_n = 1'b0;
    #1 chk("valid", outbound_buffer_valid, 32'h0);
    chk("db_status", host_irq_status[1], 32'h0);
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    host(3'h5, 32'h0);
    chk("doorbell", rd_data, 32'h0);
    close_out();
  end
endmodule : hmb_mailbox_tb
`default_nettype wire
